// ---- rtl/jbd_dma.sv ----
// DMA request and transfer sequencer for the byte decoder.
// Assumes the DMA controller grants one transfer step per grant pulse,
// and that the address and counter pairs are held here as working copies.
`timescale 1ns/10ps
`default_nettype none

module jbd_dma #(
	parameter int ADDR_W = 16,
	parameter int CNT_W  = 16
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              rx_byte_done,
	input  wire logic [7:0]        rx_data_in,
	input  wire logic              sw_rx_read,
	input  wire logic              tx_opcode_taken,
	input  wire logic              error_flag,
	input  wire logic              lost_arbitration_flag,
	input  wire logic              dma_suspend_select,
	input  wire logic [3:0]        sub_page_select,
	input  wire logic              rx_en_set,
	input  wire logic              rx_en_clr,
	input  wire logic              tx_en_set,
	input  wire logic              tx_en_clr,
	input  wire logic              rx_space_select,
	input  wire logic              tx_space_select,
	input  wire logic [7:0]        rx_addr_pointer,
	input  wire logic [7:0]        rx_count_pointer,
	input  wire logic [7:0]        tx_addr_pointer,
	input  wire logic [7:0]        tx_count_pointer,
	input  wire logic              load_pairs,
	input  wire logic [ADDR_W-1:0] rx_addr_init,
	input  wire logic [CNT_W-1:0]  rx_count_init,
	input  wire logic [ADDR_W-1:0] tx_addr_init,
	input  wire logic [CNT_W-1:0]  tx_count_init,
	input  wire logic              dma_grant,
	input  wire logic [7:0]        mem_rdata,
	input  wire logic              rx_eob_clr,
	input  wire logic              tx_eob_clr,
	output logic                   dma_req,
	output logic                   mem_we,
	output logic                   mem_space,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [7:0]             mem_wdata,
	output logic [7:0]             pair_ptr_addr,
	output logic [7:0]             pair_ptr_count,
	output logic                   rx_full_flag,
	output logic                   tx_ready_flag,
	output logic [7:0]             tx_opcode_reg,
	output logic [7:0]             tx_data_reg,
	output logic                   tx_pair_valid,
	output logic                   rx_dma_en,
	output logic                   tx_dma_en,
	output logic                   rx_block_end_pending,
	output logic                   tx_block_end_pending,
	output logic                   sub_page_bad
);

	// -----------------------------------------------------------------
	// Parameter check and helpers
	// -----------------------------------------------------------------
	if (ADDR_W < 8 || ADDR_W > 16 || CNT_W < 2 || CNT_W > 16) begin : g_bad_width
		$error("jbd_dma: unsupported pair width");
	end
	function automatic logic opcode_needs_data(input logic [7:0] op);
		logic [2:0] f;
		f = op[jbd_pkg::OPCODE_LSB +: jbd_pkg::OPCODE_W];
		return (f & jbd_pkg::OPCODE_NEEDS_DATA_MASK) != 3'h0;
	endfunction

	function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] c);
		return c - {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction

	jbd_pkg::jbd_state_t state_r;
	logic [ADDR_W-1:0]   rx_addr_r;
	logic [CNT_W-1:0]    rx_cnt_r;
	logic [ADDR_W-1:0]   tx_addr_r;
	logic [CNT_W-1:0]    tx_cnt_r;
	logic                hold;
	logic                rx_want;
	logic                tx_want;
	logic                rx_step;
	logic                tx_step;
	logic                rx_last;
	logic                tx_last;

	// Suspend only acts when selected
	assign hold    = dma_suspend_select && (error_flag || lost_arbitration_flag);
	assign rx_want = rx_full_flag && rx_dma_en && !hold;
	assign tx_want = tx_ready_flag && tx_dma_en && !hold;
	assign rx_step = (state_r == jbd_pkg::JBD_RX_XFER) && dma_grant;
	assign tx_step = ((state_r == jbd_pkg::JBD_TX_OP) || (state_r == jbd_pkg::JBD_TX_DATA))
		&& dma_grant;
	assign rx_last = rx_step && (count_step(rx_cnt_r) == '0);
	assign tx_last = tx_step && (count_step(tx_cnt_r) == '0);

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	// Receive ranks above transmit inside the block; grant order across
	// peripherals belongs to the controller, so steps simply wait.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= jbd_pkg::JBD_IDLE;
		end else begin
			case (state_r)
				jbd_pkg::JBD_IDLE: begin
					if (rx_want) begin
						state_r <= jbd_pkg::JBD_RX_XFER;
					end else if (tx_want) begin
						state_r <= jbd_pkg::JBD_TX_OP;
					end
				end
				jbd_pkg::JBD_RX_XFER: begin
					if (dma_grant) begin
						state_r <= jbd_pkg::JBD_IDLE;
					end
				end
				jbd_pkg::JBD_TX_OP: begin
					if (dma_grant) begin
						state_r <= jbd_pkg::JBD_TX_WAIT;
					end
				end
				jbd_pkg::JBD_TX_WAIT: begin
					// Data byte only if the fetched opcode asks for it
					if (opcode_needs_data(tx_opcode_reg) && tx_cnt_r != '0) begin
						state_r <= jbd_pkg::JBD_TX_DATA;
					end else begin
						state_r <= jbd_pkg::JBD_IDLE;
					end
				end
				jbd_pkg::JBD_TX_DATA: begin
					if (dma_grant) begin
						state_r <= jbd_pkg::JBD_IDLE;
					end
				end
				default: state_r <= jbd_pkg::JBD_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Bus request outputs
	// -----------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dma_req        <= 1'b0;
			mem_we         <= 1'b0;
			mem_space      <= 1'b0;
			mem_addr       <= ADDR_W'(jbd_pkg::ADDR_RST);
			mem_wdata      <= 8'h00;
			pair_ptr_addr  <= jbd_pkg::PTR_RST;
			pair_ptr_count <= jbd_pkg::PTR_RST;
		end else begin
			dma_req <= 1'b0;
			mem_we  <= 1'b0;
			if (state_r == jbd_pkg::JBD_IDLE && rx_want) begin
				dma_req        <= 1'b1;
				mem_we         <= 1'b1;
				mem_space      <= !rx_space_select;
				mem_addr       <= rx_addr_r;
				mem_wdata      <= rx_data_in;
				pair_ptr_addr  <= rx_addr_pointer;
				pair_ptr_count <= rx_count_pointer;
			end else if (state_r == jbd_pkg::JBD_IDLE && tx_want) begin
				dma_req        <= 1'b1;
				mem_space      <= !tx_space_select;
				mem_addr       <= tx_addr_r;
				pair_ptr_addr  <= tx_addr_pointer;
				pair_ptr_count <= tx_count_pointer;
			end else if (state_r == jbd_pkg::JBD_TX_WAIT
				&& opcode_needs_data(tx_opcode_reg) && tx_cnt_r != '0) begin
				dma_req  <= 1'b1;
				mem_addr <= tx_addr_r;
			end else if ((state_r == jbd_pkg::JBD_RX_XFER
				|| state_r == jbd_pkg::JBD_TX_OP
				|| state_r == jbd_pkg::JBD_TX_DATA) && !dma_grant) begin
				dma_req <= 1'b1;
				mem_we  <= mem_we;
			end
		end
	end

	// -----------------------------------------------------------------
	// Address and counter pairs
	// -----------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_addr_r <= ADDR_W'(jbd_pkg::ADDR_RST);
			rx_cnt_r  <= CNT_W'(jbd_pkg::CNT_RST);
		end else if (load_pairs) begin
			rx_addr_r <= rx_addr_init;
			rx_cnt_r  <= rx_count_init;
		end else if (rx_step) begin
			rx_addr_r <= rx_addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
			rx_cnt_r  <= count_step(rx_cnt_r);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_addr_r <= ADDR_W'(jbd_pkg::ADDR_RST);
			tx_cnt_r  <= CNT_W'(jbd_pkg::CNT_RST);
		end else if (load_pairs) begin
			tx_addr_r <= tx_addr_init;
			tx_cnt_r  <= tx_count_init;
		end else if (tx_step) begin
			tx_addr_r <= tx_addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
			tx_cnt_r  <= count_step(tx_cnt_r);
		end
	end

	// -----------------------------------------------------------------
	// Status flags
	// -----------------------------------------------------------------
	// A new byte in the same cycle as a read keeps the flag set
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_full_flag <= 1'b0;
		end else if (rx_byte_done) begin
			rx_full_flag <= 1'b1;
		end else if (sw_rx_read || rx_step) begin
			rx_full_flag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_ready_flag <= 1'b1;
		end else if (tx_opcode_taken) begin
			tx_ready_flag <= 1'b1;
		end else if (state_r == jbd_pkg::JBD_TX_OP && dma_grant) begin
			tx_ready_flag <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Transmit registers
	// -----------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_opcode_reg <= 8'h00;
			tx_data_reg   <= 8'h00;
			tx_pair_valid <= 1'b0;
		end else begin
			tx_pair_valid <= 1'b0;
			if (state_r == jbd_pkg::JBD_TX_OP && dma_grant) begin
				tx_opcode_reg <= mem_rdata;
				// Opcode without a data byte is only flagged valid with DMA enabled
				if (!opcode_needs_data(mem_rdata) && tx_dma_en) begin
					tx_pair_valid <= 1'b1;
				end
			end else if (state_r == jbd_pkg::JBD_TX_DATA && dma_grant) begin
				tx_data_reg   <= mem_rdata;
				tx_pair_valid <= tx_dma_en;
			end
		end
	end

	// -----------------------------------------------------------------
	// Enables and end-of-block pending bits
	// -----------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_dma_en <= 1'b0;
		end else if (rx_last || rx_en_clr) begin
			rx_dma_en <= 1'b0;
		end else if (rx_en_set) begin
			rx_dma_en <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_dma_en <= 1'b0;
		end else if (tx_last || tx_en_clr) begin
			tx_dma_en <= 1'b0;
		end else if (tx_en_set) begin
			tx_dma_en <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_block_end_pending <= 1'b0;
			tx_block_end_pending <= 1'b0;
		end else begin
			if (rx_last) begin
				rx_block_end_pending <= 1'b1;
			end else if (rx_eob_clr) begin
				rx_block_end_pending <= 1'b0;
			end
			if (tx_last) begin
				tx_block_end_pending <= 1'b1;
			end else if (tx_eob_clr) begin
				tx_block_end_pending <= 1'b0;
			end
		end
	end

	// Only nine sub-pages exist behind the stacked window
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sub_page_bad <= 1'b0;
		end else begin
			sub_page_bad <= 32'(sub_page_select) >= jbd_pkg::STACK_PAGES;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_suspend_holds_req: assert property (@(posedge clock) disable iff (!nrst)
		(state_r == jbd_pkg::JBD_IDLE && hold) |=> !dma_req)
		else $error("request raised while suspended");
	a_rx_clear_after: assert property (@(posedge clock) disable iff (!nrst)
		(rx_step && !rx_byte_done) |=> !rx_full_flag)
		else $error("receive flag not cleared");
	a_rx_addr_step: assert property (@(posedge clock) disable iff (!nrst)
		(rx_step && !load_pairs) |=> rx_addr_r == $past(rx_addr_r) + 1'b1)
		else $error("receive address not stepped");
	a_rx_en_drop: assert property (@(posedge clock) disable iff (!nrst)
		rx_last |=> !rx_dma_en && rx_block_end_pending)
		else $error("receive enable kept at block end");
	a_tx_en_drop: assert property (@(posedge clock) disable iff (!nrst)
		tx_last |=> !tx_dma_en && tx_block_end_pending)
		else $error("transmit enable kept at block end");
	a_tx_data_follow: assert property (@(posedge clock) disable iff (!nrst)
		(state_r == jbd_pkg::JBD_TX_WAIT && !opcode_needs_data(tx_opcode_reg))
		|=> state_r == jbd_pkg::JBD_IDLE)
		else $error("data fetched for a bare opcode");
	a_no_req_disabled: assert property (@(posedge clock) disable iff (!nrst)
		(state_r == jbd_pkg::JBD_IDLE && !rx_dma_en && !tx_dma_en) |=> !dma_req)
		else $error("request while disabled");
	a_rx_read_clear: assert property (@(posedge clock) disable iff (!nrst)
		(sw_rx_read && !rx_byte_done) |=> !rx_full_flag)
		else $error("read left receive flag set");

endmodule // jbd_dma

`default_nettype wire

// ---- rtl/jbd_pkg.sv ----
// Package of constants for the byte decoder DMA request and transfer block.
// Assumes a single core clock domain shared with the DMA controller.
package jbd_pkg;

	// -----------------------------------------------------------------
	// Register page and map
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_PAGE       = 8'h17;
	localparam logic [7:0] CTRL_FIRST     = 8'hF0;
	localparam logic [7:0] CTRL_LAST      = 8'hFB;
	localparam logic [7:0] STACK_FIRST    = 8'hFC;
	localparam int         STACK_PAGES    = 9;
	localparam int         STACK_REGS     = 4;
	localparam logic [7:0] RF_LIMIT       = 8'hDF;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int         SPACE_SEL_BIT  = 0;
	localparam int         OPCODE_LSB     = 0;
	localparam int         OPCODE_W       = 3;
	localparam logic [2:0] OPCODE_NEEDS_DATA_MASK = 3'h1;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0]  PTR_RST       = 8'h00;
	localparam logic [15:0] CNT_RST       = 16'h0000;
	localparam logic [15:0] ADDR_RST      = 16'h0000;

	// -----------------------------------------------------------------
	// Sequencer states
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		JBD_IDLE    = 3'b000,
		JBD_RX_XFER = 3'b001,
		JBD_TX_OP   = 3'b010,
		JBD_TX_WAIT = 3'b011,
		JBD_TX_DATA = 3'b100
	} jbd_state_t;

endpackage

// ---- bench/jbd_dma_partner.sv ----
// Behavioural DMA controller with a byte memory, facing the transfer sequencer.
// Assumes one core clock; grants one step per request after lat idle cycles.
`timescale 1ns/10ps
`default_nettype none

module jbd_dma_partner (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        dma_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic [3:0]  lat,
	output logic             dma_grant,
	output logic [7:0]       mem_rdata,
	output logic [7:0]       grant_cnt
);
	logic [7:0] mem [0:1023];
	logic [3:0] wait_r;

	// -----------------------------------------------------------------
	// Grant and memory step
	// -----------------------------------------------------------------
	// Slow grants model higher-priority traffic in between
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dma_grant <= 1'b0;
			wait_r    <= 4'h0;
			grant_cnt <= 8'h00;
			mem_rdata <= 8'h00;
		end else begin
			dma_grant <= 1'b0;
			// Idle bus toggles so stale table data is never read by luck
			mem_rdata <= ~mem_rdata;
			if (dma_req && !dma_grant) begin
				if (wait_r >= lat) begin
					dma_grant <= 1'b1;
					mem_rdata <= mem[mem_addr[9:0]];
					wait_r    <= 4'h0;
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end
			if (dma_grant) begin
				grant_cnt <= grant_cnt + 8'h01;
				if (mem_we) begin
					mem[mem_addr[9:0]] <= mem_wdata;
				end
			end
		end
	end
endmodule // jbd_dma_partner

`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the byte decoder DMA sequencer.
// Assumes the partner model for grants; inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        clock = 1'b0, nrst = 1'b0;
	logic        rx_byte_done = 1'b0, sw_rx_read = 1'b0, tx_opcode_taken = 1'b0;
	logic        error_flag = 1'b0, lost_arbitration_flag = 1'b0, dma_suspend_select = 1'b0;
	logic        rx_en_set = 1'b0, rx_en_clr = 1'b0, tx_en_set = 1'b0, tx_en_clr = 1'b0;
	logic        rx_space_select = 1'b0, tx_space_select = 1'b1, load_pairs = 1'b0;
	logic        rx_eob_clr = 1'b0, tx_eob_clr = 1'b0, dma_grant, dma_req, mem_we, mem_space;
	logic        rx_full_flag, tx_ready_flag, tx_pair_valid, rx_dma_en, tx_dma_en;
	logic        rx_block_end_pending, tx_block_end_pending, sub_page_bad;
	logic [3:0]  sub_page_select = 4'h0, lat = 4'h0;
	logic [7:0]  rx_data_in = 8'h00, mem_rdata, mem_wdata, pair_ptr_addr, pair_ptr_count;
	logic [7:0]  tx_opcode_reg, tx_data_reg, grant_cnt;
	logic [15:0] rx_addr_init = 16'h0100, rx_count_init = 16'h0002, mem_addr;
	logic [15:0] tx_addr_init = 16'h0200, tx_count_init = 16'h0003;
	int          err_count = 0, cmp_count = 0, pv_cnt = 0;

	always #50 clock = ~clock;
	always @(negedge clock) if (tx_pair_valid === 1'b1) pv_cnt++;

	jbd_dma i_jbd_dma (.clock(clock), .nrst(nrst), .rx_byte_done(rx_byte_done),
		.rx_data_in(rx_data_in), .sw_rx_read(sw_rx_read), .tx_opcode_taken(tx_opcode_taken),
		.error_flag(error_flag), .lost_arbitration_flag(lost_arbitration_flag),
		.dma_suspend_select(dma_suspend_select), .sub_page_select(sub_page_select),
		.rx_en_set(rx_en_set), .rx_en_clr(rx_en_clr), .tx_en_set(tx_en_set),
		.tx_en_clr(tx_en_clr), .rx_space_select(rx_space_select),
		.tx_space_select(tx_space_select), .rx_addr_pointer(8'h10), .rx_count_pointer(8'h12),
		.tx_addr_pointer(8'h20), .tx_count_pointer(8'h22), .load_pairs(load_pairs),
		.rx_addr_init(rx_addr_init), .rx_count_init(rx_count_init),
		.tx_addr_init(tx_addr_init), .tx_count_init(tx_count_init), .dma_grant(dma_grant),
		.mem_rdata(mem_rdata), .rx_eob_clr(rx_eob_clr), .tx_eob_clr(tx_eob_clr),
		.dma_req(dma_req), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .pair_ptr_addr(pair_ptr_addr), .pair_ptr_count(pair_ptr_count),
		.rx_full_flag(rx_full_flag), .tx_ready_flag(tx_ready_flag),
		.tx_opcode_reg(tx_opcode_reg), .tx_data_reg(tx_data_reg),
		.tx_pair_valid(tx_pair_valid), .rx_dma_en(rx_dma_en), .tx_dma_en(tx_dma_en),
		.rx_block_end_pending(rx_block_end_pending),
		.tx_block_end_pending(tx_block_end_pending), .sub_page_bad(sub_page_bad));

	jbd_dma_partner i_jbd_dma_partner (.clock(clock), .nrst(nrst), .dma_req(dma_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
		.dma_grant(dma_grant), .mem_rdata(mem_rdata), .grant_cnt(grant_cnt));

	// -----------------------------------------------------------------
	// Access tasks
	// -----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic rx_byte(input logic [7:0] d);
		@(negedge clock);
		rx_data_in   = d;
		rx_byte_done = 1'b1;
		@(negedge clock);
		rx_byte_done = 1'b0;
	endtask

	task automatic wait_req;
		int i;
		i = 0;
		while (dma_req !== 1'b1 && i < 100) begin
			@(negedge clock);
			i++;
		end
		chk("request seen", 16'h0001, {15'h0000, dma_req});
	endtask

	// Bounded wait for the partner's grant count, then let the step settle
	task automatic wait_grants(input logic [7:0] n);
		int i;
		i = 0;
		while (grant_cnt !== n && i < 300) begin
			@(negedge clock);
			i++;
		end
		cyc(2);
		chk("grant count", {8'h00, n}, {8'h00, grant_cnt});
	endtask

	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clock);
			if (dma_req !== 1'b0) seen = 1'b1;
		end
		chk("request absent", 16'h0000, {15'h0000, seen});
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 100);
		err_count++;
		$display("BAD watchdog expected finish seen hang");
		test_done;
	end

	// -----------------------------------------------------------------
	// Test sequence
	// -----------------------------------------------------------------
	initial begin
		i_jbd_dma_partner.mem[10'h200] = 8'h01;
		i_jbd_dma_partner.mem[10'h201] = 8'h33;
		i_jbd_dma_partner.mem[10'h202] = 8'h02;
		cyc(20);
		nrst = 1'b1;
		cyc(1);
		chk("tx ready at reset", 16'h0001, {15'h0000, tx_ready_flag});
		chk("rx enable at reset", 16'h0000, {15'h0000, rx_dma_en});
		for (int v = 0; v < 16; v++) begin
			sub_page_select = v[3:0];
			cyc(2);
			chk("sub page bad", {15'h0000, v >= 9}, {15'h0000, sub_page_bad});
		end
		load_pairs = 1'b1;
		cyc(1);
		load_pairs = 1'b0;
		rx_byte(8'hA5);
		quiet(10);
		chk("rx full", 16'h0001, {15'h0000, rx_full_flag});
		rx_en_set = 1'b1;
		cyc(1);
		rx_en_set = 1'b0;
		wait_req();
		chk("rx write enable", 16'h0001, {15'h0000, mem_we});
		chk("rx memory space", 16'h0001, {15'h0000, mem_space});
		chk("rx addr pointer", 16'h0010, {8'h00, pair_ptr_addr});
		chk("rx count pointer", 16'h0012, {8'h00, pair_ptr_count});
		chk("rx address", 16'h0100, mem_addr);
		chk("rx data out", 16'h00A5, {8'h00, mem_wdata});
		wait_grants(8'h01);
		chk("rx byte stored", 16'h00A5, {8'h00, i_jbd_dma_partner.mem[10'h100]});
		chk("rx full after step", 16'h0000, {15'h0000, rx_full_flag});
		dma_suspend_select = 1'b1;
		error_flag = 1'b1;
		rx_byte(8'h5A);
		quiet(10);
		error_flag = 1'b0;
		wait_grants(8'h02);
		chk("rx next address", 16'h005A, {8'h00, i_jbd_dma_partner.mem[10'h101]});
		chk("rx enable at end", 16'h0000, {15'h0000, rx_dma_en});
		chk("rx block end", 16'h0001, {15'h0000, rx_block_end_pending});
		rx_byte(8'hC3);
		quiet(10);
		sw_rx_read = 1'b1;
		rx_eob_clr = 1'b1;
		cyc(1);
		sw_rx_read = 1'b0;
		rx_eob_clr = 1'b0;
		cyc(1);
		chk("rx full after read", 16'h0000, {15'h0000, rx_full_flag});
		chk("rx block end clear", 16'h0000, {15'h0000, rx_block_end_pending});
		load_pairs = 1'b1;
		rx_en_set  = 1'b1;
		dma_suspend_select = 1'b0;
		lost_arbitration_flag = 1'b1;
		cyc(1);
		load_pairs = 1'b0;
		rx_en_set  = 1'b0;
		rx_byte(8'h3C);
		wait_grants(8'h03);
		chk("rx reloaded table", 16'h003C, {8'h00, i_jbd_dma_partner.mem[10'h100]});
		rx_en_clr = 1'b1;
		cyc(1);
		rx_en_clr = 1'b0;
		rx_byte(8'h11);
		quiet(10);
		lat = 4'h3;
		tx_en_set = 1'b1;
		cyc(1);
		tx_en_set = 1'b0;
		wait_req();
		chk("tx register space", 16'h0000, {15'h0000, mem_space});
		chk("tx addr pointer", 16'h0020, {8'h00, pair_ptr_addr});
		chk("tx count pointer", 16'h0022, {8'h00, pair_ptr_count});
		chk("tx read", 16'h0000, {15'h0000, mem_we});
		wait_grants(8'h05);
		chk("tx opcode", 16'h0001, {8'h00, tx_opcode_reg});
		chk("tx data", 16'h0033, {8'h00, tx_data_reg});
		chk("tx ready cleared", 16'h0000, {15'h0000, tx_ready_flag});
		chk("tx pair valid", 16'h0001, pv_cnt[15:0]);
		tx_opcode_taken = 1'b1;
		cyc(1);
		tx_opcode_taken = 1'b0;
		wait_grants(8'h06);
		quiet(10);
		chk("tx single opcode", 16'h0002, {8'h00, tx_opcode_reg});
		chk("tx pair valid single", 16'h0002, pv_cnt[15:0]);
		chk("tx enable at end", 16'h0000, {15'h0000, tx_dma_en});
		chk("tx block end", 16'h0001, {15'h0000, tx_block_end_pending});
		tx_eob_clr = 1'b1;
		cyc(1);
		tx_eob_clr = 1'b0;
		cyc(1);
		chk("tx block end clear", 16'h0000, {15'h0000, tx_block_end_pending});
		test_done;
	end
endmodule // tb

`default_nettype wire
